// ---- core/pwc_defs.svh ----
// constants for the periodic wakeup counter
// assumes one 100 MHz clock and source clocks sampled as synchronous levels
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH

`define PWC_SRC_LOW_POWER  2'h0
`define PWC_SRC_EXTERNAL   2'h1
`define PWC_DIV_OFF        4'h0
`define PWC_DIV_DECIMAL    4'h8
`define PWC_RST_SOURCE     2'h0
`define PWC_RST_DIVIDE     4'h0
`define PWC_RST_COMPARE    8'h00
`define PWC_RST_COUNT      8'h00
`define PWC_RST_PRESCALER  18'h00000
`define PWC_BIN_LOW_BASE   5'h03
`define PWC_BIN_LOW_FIRST  5'h03
`define PWC_BIN_HIGH_BASE  5'h09

`endif

// ---- core/pwc_pkg.sv ----
// types for the periodic wakeup counter
// assumes the constants header is included by the design file
package pwc_pkg;

  typedef enum logic [1:0] {
    src_low_power,
    src_external,
    src_internal
  } clock_source_t;

  typedef logic [17:0] divide_ratio_t;

endpackage

// ---- core/periodic_wakeup_counter.sv ----
// periodic wakeup counter: prescaler, 8-bit counter, compare match flag
// assumes control writes arrive as one-cycle strobes with their field values
// and that the three source clocks are slow levels already synchronous
`include "pwc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module periodic_wakeup_counter (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       low_power_osc_clk,
  input  wire logic       external_ref_clk,
  input  wire logic       internal_ref_clk,
  input  wire logic       control_wr,
  input  wire logic [1:0] wr_source_select,
  input  wire logic [3:0] wr_divide_select,
  input  wire logic       wr_match_irq_enable,
  input  wire logic       wr_match_flag,
  input  wire logic       compare_wr,
  input  wire logic [7:0] wr_compare_value,
  input  wire logic       count_wr,
  output logic      [1:0] source_select,
  output logic      [3:0] divide_select,
  output logic            match_irq_enable,
  output logic      [7:0] compare_value,
  output logic      [7:0] tick_count,
  output logic            match_flag,
  output logic            match_irq
);

  function automatic pwc_pkg::clock_source_t decode_source(
    input logic [1:0] sel
  );
    unique case (sel)
      `PWC_SRC_LOW_POWER: decode_source = pwc_pkg::src_low_power;
      `PWC_SRC_EXTERNAL:  decode_source = pwc_pkg::src_external;
      default:            decode_source = pwc_pkg::src_internal;
    endcase
  endfunction

  // decimal ratios for codes 8 to 15, low and high source bit 0
  function automatic pwc_pkg::divide_ratio_t decimal_ratio(
    input logic [2:0] idx,
    input logic       high
  );
    unique case ({high, idx})
      4'h0:    decimal_ratio = 18'h00001;
      4'h1:    decimal_ratio = 18'h00002;
      4'h2:    decimal_ratio = 18'h00004;
      4'h3:    decimal_ratio = 18'h0000a;
      4'h4:    decimal_ratio = 18'h00010;
      4'h5:    decimal_ratio = 18'h00064;
      4'h6:    decimal_ratio = 18'h001f4;
      4'h7:    decimal_ratio = 18'h003e8;
      4'h8:    decimal_ratio = 18'h003e8;
      4'h9:    decimal_ratio = 18'h007d0;
      4'ha:    decimal_ratio = 18'h01388;
      4'hb:    decimal_ratio = 18'h02710;
      4'hc:    decimal_ratio = 18'h04e20;
      4'hd:    decimal_ratio = 18'h0c350;
      4'he:    decimal_ratio = 18'h186a0;
      default: decimal_ratio = 18'h30d40;
    endcase
  endfunction

  function automatic pwc_pkg::divide_ratio_t divide_ratio(
    input logic [3:0] code,
    input logic       high
  );
    logic [4:0] expo;
    expo = 5'h00;
    if (code >= `PWC_DIV_DECIMAL) begin
      divide_ratio = decimal_ratio(code[2:0], high);
    end else begin
      if (high) begin
        expo = `PWC_BIN_HIGH_BASE + {2'h0, code[2:0]};
      end else if (code[2:0] == 3'h1) begin
        expo = `PWC_BIN_LOW_FIRST;
      end else begin
        expo = `PWC_BIN_LOW_BASE + {2'h0, code[2:0]};
      end
      divide_ratio = 18'h00001 << expo;
    end
  endfunction

  logic                  src_level;
  logic                  src_prev;
  logic                  src_edge;
  logic                  prescaler_on;
  logic                  settings_clear;
  logic                  presc_tick;
  logic                  match_event;
  logic                  flag_clear;
  logic           [17:0] prescaler;
  pwc_pkg::divide_ratio_t ratio;

  // source multiplexer
  always_comb begin
    src_level = 1'b0;
    unique case (decode_source(source_select))
      pwc_pkg::src_low_power: src_level = low_power_osc_clk;
      pwc_pkg::src_external:  src_level = external_ref_clk;
      pwc_pkg::src_internal:  src_level = internal_ref_clk;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      src_prev <= 1'b0;
    end else begin
      src_prev <= src_level;
    end
  end

  assign src_edge     = src_level & ~src_prev;
  assign prescaler_on = divide_select != `PWC_DIV_OFF;
  assign ratio        = divide_ratio(divide_select, source_select[0]);

  // changed source or divide selects or any compare write restart the count
  assign settings_clear = (control_wr && (wr_source_select != source_select))
                       || (control_wr && (wr_divide_select != divide_select))
                       || compare_wr;

  assign presc_tick = prescaler_on && src_edge && !settings_clear
                   && (prescaler == (ratio - 18'h00001));
  assign match_event = presc_tick && (tick_count == compare_value);
  assign flag_clear  = control_wr && wr_match_flag;

  // control fields
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      source_select    <= `PWC_RST_SOURCE;
      divide_select    <= `PWC_RST_DIVIDE;
      match_irq_enable <= 1'b0;
    end else if (control_wr) begin
      source_select    <= wr_source_select;
      divide_select    <= wr_divide_select;
      match_irq_enable <= wr_match_irq_enable;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      compare_value <= `PWC_RST_COMPARE;
    end else if (compare_wr) begin
      compare_value <= wr_compare_value;
    end
  end

  // prescaler
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prescaler <= `PWC_RST_PRESCALER;
    end else if (settings_clear) begin
      prescaler <= `PWC_RST_PRESCALER;
    end else if (presc_tick) begin
      prescaler <= `PWC_RST_PRESCALER;
    end else if (prescaler_on && src_edge) begin
      prescaler <= prescaler + 18'h00001;
    end
  end

  // main counter, count writes are ignored
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_count <= `PWC_RST_COUNT;
    end else if (settings_clear) begin
      tick_count <= `PWC_RST_COUNT;
    end else if (match_event) begin
      tick_count <= `PWC_RST_COUNT;
    end else if (presc_tick) begin
      tick_count <= tick_count + 8'h01;
    end
  end

  // sticky flag, a match in the clearing cycle wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      match_flag <= 1'b0;
    end else if (match_event) begin
      match_flag <= 1'b1;
    end else if (flag_clear) begin
      match_flag <= 1'b0;
    end
  end

  assign match_irq = match_flag && match_irq_enable;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_OFF_HOLDS: assert property (
    (divide_select == `PWC_DIV_OFF) && !control_wr && !compare_wr
    |=> (tick_count == $past(tick_count)) && $stable(match_flag)
  ) else $error("counter moved while prescaler off");

  AST_SOURCE_CHANGE_CLEARS: assert property (
    control_wr && (wr_source_select != source_select)
    |=> (tick_count == 8'h00) && (prescaler == 18'h00000)
  ) else $error("source change did not clear counters");

  AST_DIVIDE_CHANGE_CLEARS: assert property (
    control_wr && (wr_divide_select != divide_select)
    |=> (tick_count == 8'h00) && (prescaler == 18'h00000)
  ) else $error("divide change did not clear counters");

  AST_COMPARE_WRITE_CLEARS: assert property (
    compare_wr
    |=> (tick_count == 8'h00) && (compare_value == $past(wr_compare_value))
  ) else $error("compare write did not clear counters");

  AST_MATCH_WRAPS: assert property (
    match_event |=> (tick_count == 8'h00) && match_flag
  ) else $error("match did not wrap and flag");

  AST_COUNT_STEPS: assert property (
    presc_tick && (tick_count != compare_value)
    |=> tick_count == $past(tick_count) + 8'h01
  ) else $error("counter did not step by one");

  AST_ZERO_COMPARE_FLAGS: assert property (
    (compare_value == 8'h00) && presc_tick |=> match_flag && (tick_count == 8'h00)
  ) else $error("zero compare did not flag each tick");

  AST_REQUEST_FOLLOWS: assert property (
    match_event && match_irq_enable && !control_wr |=> match_irq
  ) else $error("request missing after enabled match");

  AST_REQUEST_MASKED: assert property (
    !match_irq_enable |-> !match_irq
  ) else $error("request raised while disabled");

  AST_FLAG_CLEARED: assert property (
    flag_clear && !match_event |=> !match_flag && !match_irq
  ) else $error("flag not cleared by write of one");

  AST_FLAG_KEPT: assert property (
    control_wr && !wr_match_flag && match_flag |=> match_flag
  ) else $error("flag lost on write of zero");

  AST_COUNT_WRITE_IGNORED: assert property (
    count_wr && !presc_tick && !settings_clear |=> $stable(tick_count)
  ) else $error("count write changed the counter");

  AST_DIVIDE_BY_ONE: assert property (
    (divide_select == `PWC_DIV_DECIMAL) && !source_select[0]
    && src_edge && !settings_clear |-> presc_tick
  ) else $error("divide by one missed an edge");

  AST_LOW_POWER_SOURCE: assert property (
    source_select == `PWC_SRC_LOW_POWER |-> src_level == low_power_osc_clk
  ) else $error("wrong source selected");

  AST_EXTERNAL_SOURCE: assert property (
    source_select == `PWC_SRC_EXTERNAL |-> src_level == external_ref_clk
  ) else $error("external source not selected");

  AST_INTERNAL_SOURCE: assert property (
    source_select[1] |-> src_level == internal_ref_clk
  ) else $error("internal source not selected");

  // settings and compare value only move on their own strobes
  AST_SETTINGS_HELD: assert property (
    !control_wr
    |=> $stable(source_select) && $stable(divide_select) && $stable(match_irq_enable)
  ) else $error("control fields changed without a write");

  AST_ENABLE_TAKEN: assert property (
    control_wr |=> match_irq_enable == $past(wr_match_irq_enable)
  ) else $error("enable write not taken");

  AST_COMPARE_HELD: assert property (
    !compare_wr |=> $stable(compare_value)
  ) else $error("compare value changed without a write");

  // rewriting the current settings must not restart the count
  AST_SAME_SETTINGS_KEEP: assert property (
    control_wr && (wr_source_select == source_select)
    && (wr_divide_select == divide_select) && !compare_wr && !presc_tick
    |=> $stable(tick_count)
  ) else $error("same settings write disturbed the counter");

  AST_PRESCALER_BELOW_RATIO: assert property (
    prescaler_on |-> prescaler < ratio
  ) else $error("prescaler ran past its ratio");

  AST_PRESCALER_STEPS: assert property (
    prescaler_on && src_edge && !settings_clear && !presc_tick
    |=> prescaler == $past(prescaler) + 18'h00001
  ) else $error("prescaler did not count a source edge");

  AST_IDLE_NO_TICK: assert property (
    prescaler_on && !src_edge && !settings_clear
    |=> $stable(prescaler) && $stable(tick_count)
  ) else $error("counter moved without a source edge");

  AST_FLAG_ONLY_ON_MATCH: assert property (
    !match_flag && !match_event |=> !match_flag
  ) else $error("flag set without a match");

  COV_MATCH: cover property (match_event);
  COV_REQUEST: cover property (!match_irq ##1 match_irq);
  COV_FLAG_CLEAR: cover property (match_flag ##1 flag_clear ##1 !match_flag);
  COV_SET_WINS: cover property (match_event && flag_clear);
  COV_HIGH_RATIO_TICK: cover property (presc_tick && source_select[0]);

endmodule

`default_nettype wire

// ---- tb/periodic_wakeup_counter_tb_top.sv ----
// self-checking bench for the periodic wakeup counter
// assumes the design's assertions sit in its own file; source clocks made here
`timescale 1ns/1ps
`default_nettype none

module periodic_wakeup_counter_tb_top;
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic [2:0] src_lv = 3'h0;
  logic       control_wr = 1'b0;
  logic [1:0] wr_source_select = 2'h0;
  logic [3:0] wr_divide_select = 4'h0;
  logic       wr_match_irq_enable = 1'b0;
  logic       wr_match_flag = 1'b0;
  logic       compare_wr = 1'b0;
  logic [7:0] wr_compare_value = 8'h00;
  logic       count_wr = 1'b0;
  logic [1:0] source_select;
  logic [3:0] divide_select;
  logic       match_irq_enable;
  logic [7:0] compare_value;
  logic [7:0] tick_count;
  logic       match_flag;
  logic       match_irq;
  int         errors = 0;
  int         tests_run = 0;
  logic [1:0] rs [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  logic [3:0] rd [10] = '{4'h1, 4'h2, 4'h7, 4'h8, 4'hb, 4'hf, 4'h1, 4'h8, 4'ha, 4'h9};
  int         rn [10] = '{8, 32, 1024, 1, 10, 1000, 1024, 1000, 4, 2000};

  periodic_wakeup_counter dut_u (
    .clock               (clock),
    .rstn                (rstn),
    .low_power_osc_clk   (src_lv[0]),
    .external_ref_clk    (src_lv[1]),
    .internal_ref_clk    (src_lv[2]),
    .control_wr          (control_wr),
    .wr_source_select    (wr_source_select),
    .wr_divide_select    (wr_divide_select),
    .wr_match_irq_enable (wr_match_irq_enable),
    .wr_match_flag       (wr_match_flag),
    .compare_wr          (compare_wr),
    .wr_compare_value    (wr_compare_value),
    .count_wr            (count_wr),
    .source_select       (source_select),
    .divide_select       (divide_select),
    .match_irq_enable    (match_irq_enable),
    .compare_value       (compare_value),
    .tick_count          (tick_count),
    .match_flag          (match_flag),
    .match_irq           (match_irq)
  );

  always #5 clock = ~clock;

  task automatic end_sim;
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic ctl(input logic [1:0] s, input logic [3:0] d, input logic ie, input logic f);
    @(negedge clock);
    control_wr = 1'b1;
    wr_source_select = s;
    wr_divide_select = d;
    wr_match_irq_enable = ie;
    wr_match_flag = f;
    @(negedge clock);
    control_wr = 1'b0;
  endtask

  task automatic cmp(input logic [7:0] v);
    @(negedge clock);
    compare_wr = 1'b1;
    wr_compare_value = v;
    @(negedge clock);
    compare_wr = 1'b0;
  endtask

  // n rising edges on the line that source code s selects
  task automatic pulse(input logic [1:0] s, input int n);
    int i;
    i = s[1] ? 2 : (s[0] ? 1 : 0);
    repeat (n) begin
      @(negedge clock);
      src_lv[i] = 1'b1;
      @(negedge clock);
      src_lv[i] = 1'b0;
    end
    repeat (2) @(negedge clock);
  endtask

  task automatic ratio(input logic [1:0] s, input logic [3:0] d, input int n);
    cmp(8'hff);
    ctl(s, d, 1'b0, 1'b1);
    pulse(s, n - 1);
    chk("tick_count", 8'h00, tick_count);
    pulse(s, 1);
    chk("tick_count", 8'h01, tick_count);
  endtask

  initial begin
    #400000;
    errors++;
    end_sim();
  end

  initial begin
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    chk("source_select", 8'h00, {6'h0, source_select});
    chk("divide_select", 8'h00, {4'h0, divide_select});
    chk("compare_value", 8'h00, compare_value);
    chk("tick_count", 8'h00, tick_count);
    chk("match_irq_enable", 8'h00, {7'h0, match_irq_enable});
    chk("match_irq", 8'h00, {7'h0, match_irq});
    pulse(2'h0, 3);
    chk("tick_count", 8'h00, tick_count);
    chk("match_flag", 8'h00, {7'h0, match_flag});
    ctl(2'h0, 4'h8, 1'b1, 1'b0);
    chk("divide_select", 8'h08, {4'h0, divide_select});
    chk("match_irq_enable", 8'h01, {7'h0, match_irq_enable});
    cmp(8'h01);
    chk("compare_value", 8'h01, compare_value);
    pulse(2'h0, 1);
    chk("tick_count", 8'h01, tick_count);
    @(negedge clock);
    count_wr = 1'b1;
    @(negedge clock);
    count_wr = 1'b0;
    chk("tick_count", 8'h01, tick_count);
    chk("match_flag", 8'h00, {7'h0, match_flag});
    pulse(2'h0, 1);
    chk("tick_count", 8'h00, tick_count);
    chk("match_irq", 8'h01, {7'h0, match_irq});
    ctl(2'h0, 4'h8, 1'b0, 1'b0);
    chk("match_flag", 8'h01, {7'h0, match_flag});
    chk("match_irq", 8'h00, {7'h0, match_irq});
    ctl(2'h0, 4'h8, 1'b1, 1'b1);
    chk("match_flag", 8'h00, {7'h0, match_flag});
    cmp(8'h00);
    pulse(2'h0, 1);
    chk("match_irq", 8'h01, {7'h0, match_irq});
    ctl(2'h0, 4'h8, 1'b1, 1'b1);
    chk("match_irq", 8'h00, {7'h0, match_irq});
    pulse(2'h0, 1);
    chk("match_flag", 8'h01, {7'h0, match_flag});
    // a match and a clearing write in one cycle: the match wins
    @(negedge clock);
    src_lv[0] = 1'b1;
    control_wr = 1'b1;
    wr_match_flag = 1'b1;
    @(negedge clock);
    src_lv[0] = 1'b0;
    control_wr = 1'b0;
    chk("match_flag", 8'h01, {7'h0, match_flag});
    cmp(8'h10);
    pulse(2'h0, 3);
    chk("tick_count", 8'h03, tick_count);
    cmp(8'h10);
    chk("tick_count", 8'h00, tick_count);
    pulse(2'h0, 2);
    ctl(2'h0, 4'h9, 1'b1, 1'b0);
    chk("tick_count", 8'h00, tick_count);
    pulse(2'h0, 2);
    chk("tick_count", 8'h01, tick_count);
    ctl(2'h1, 4'h9, 1'b1, 1'b0);
    chk("tick_count", 8'h00, tick_count);
    ctl(2'h1, 4'h8, 1'b1, 1'b0);
    chk("source_select", 8'h01, {6'h0, source_select});
    ctl(2'h2, 4'h8, 1'b1, 1'b0);
    pulse(2'h0, 3);
    pulse(2'h1, 3);
    chk("tick_count", 8'h00, tick_count);
    pulse(2'h2, 1);
    chk("tick_count", 8'h01, tick_count);
    // reset in mid-run with count, flag and request all set
    @(negedge clock);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    chk("source_select", 8'h00, {6'h0, source_select});
    chk("divide_select", 8'h00, {4'h0, divide_select});
    chk("compare_value", 8'h00, compare_value);
    chk("tick_count", 8'h00, tick_count);
    chk("match_irq_enable", 8'h00, {7'h0, match_irq_enable});
    chk("match_flag", 8'h00, {7'h0, match_flag});
    chk("match_irq", 8'h00, {7'h0, match_irq});
    for (int k = 0; k < 10; k++)
      ratio(rs[k], rd[k], rn[k]);
    end_sim();
  end
endmodule

`default_nettype wire
